// *** core/cra_pkg.sv ***
// column readout addressing: shared constants, register map and types
// assumes a single 40 MHz system clock and an APB register slave
package cra_pkg;

   // ------------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------------
   localparam int unsigned NUM_STG = 640;  // pointer stages, two columns each
   localparam int unsigned COL_W   = 11;   // column index width
   localparam int unsigned STG_W   = 10;   // stage index width
   localparam int unsigned PIX_W   = 10;   // pixel sample width

   // ------------------------------------------------------------------
   // register map (byte addresses) and fields
   // ------------------------------------------------------------------
   localparam logic [11:0] REG_CTRL  = 12'h000;  // mode and swap controls
   localparam logic [11:0] REG_START = 12'h004;  // window start column
   localparam logic [11:0] REG_STOP  = 12'h008;  // window last column
   localparam logic [11:0] REG_STAT  = 12'h00C;  // busy flag and stage
   localparam int unsigned CTRL_SUB_BIT   = 0;   // sub-sampling enable
   localparam int unsigned CTRL_INNER_BIT = 1;   // column_inner_swap_bit
   localparam int unsigned CTRL_OUTER_BIT = 2;   // column_outer_swap_bit
   localparam int unsigned STAT_BUSY_BIT  = 0;   // row readout running
   localparam int unsigned STAT_STG_LSB   = 16;  // current stage field
   localparam logic [COL_W-1:0] START_RST = 11'h000;
   localparam logic [COL_W-1:0] STOP_RST  = 11'h4FF;

   // ------------------------------------------------------------------
   // pointer steps and column offsets per pattern {bus a, bus b}
   // ------------------------------------------------------------------
   localparam logic [STG_W:0] STEP_ONE  = 11'h001;
   localparam logic [STG_W:0] STEP_TWO  = 11'h002;
   localparam logic [3:0]     OFF_PLAIN = 4'h1;  // columns 0,1 of the pair
   localparam logic [3:0]     OFF_INNER = 4'h2;  // columns 0,2 of four
   localparam logic [3:0]     OFF_OUTER = 4'h7;  // columns 1,3 of four
   localparam logic [3:0]     OFF_BOTH  = 4'hB;  // columns 2,3 of four

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } cra_state_t;

endpackage : cra_pkg

// *** core/cra_stream_if.sv ***
// column readout addressing: link between the sequencer and the merger
// assumes both ends run on the one system clock
`timescale 1ns/100ps
`default_nettype none
interface cra_stream_if
   import cra_pkg::*;
();
   logic             run;       // column pair selected this cycle
   logic             phase;     // 0: bus a slot, 1: bus b slot
   logic [PIX_W-1:0] bus_a;     // even-column bus sample
   logic [PIX_W-1:0] bus_b;     // odd-column bus sample
   logic [COL_W-1:0] col_a;     // column on bus a
   logic [COL_W-1:0] col_b;     // column on bus b
   logic [PIX_W-1:0] pix_data;  // merged pixel
   logic [COL_W-1:0] pix_col;   // merged pixel column
   logic             pix_valid; // merged pixel valid

   modport core  (output run, phase, bus_a, bus_b, col_a, col_b,
                  input  pix_data, pix_col, pix_valid);
   modport merge (input  run, phase, bus_a, bus_b, col_a, col_b,
                  output pix_data, pix_col, pix_valid);
endinterface : cra_stream_if
`default_nettype wire

// *** core/cra_col_ptr.sv ***
// column readout addressing: one-hot column pointer with start decoder
// assumes load and shift come from the sequencer, never both at once
`timescale 1ns/100ps
`default_nettype none
module cra_col_ptr
   import cra_pkg::*;
(
   input  wire logic             clk_i,       // system clock
   input  wire logic             rst_n_i,     // sync reset, active low
   input  wire logic             load_i,      // start-load window
   input  wire logic [STG_W-1:0] start_stg_i, // decoded start stage
   input  wire logic             shift_i,     // half-rate shift enable
   input  wire logic             two_i,       // shift by two stages
   output logic                  active_o,    // a stage is still set
   output logic      [STG_W-1:0] stage_o      // index of the set stage
);
   logic [NUM_STG-1:0] ptr_r;    // one-hot pointer
   logic [NUM_STG-1:0] ptr_nxt;  // next pointer
   logic [STG_W-1:0]   stage_r;  // binary shadow of the pointer

   // ------------------------------------------------------------------
   // per-stage next value: decoder load, shift by one or by two
   // ------------------------------------------------------------------
   genvar k;
   for (k = 0; k < NUM_STG; k++) begin : g_stage
      logic prev1;  // stage one to the left
      logic prev2;  // stage two to the left
      if (k > 0) begin : g_p1
         assign prev1 = ptr_r[k-1];
      end else begin : g_z1
         assign prev1 = 1'b0;
      end
      if (k > 1) begin : g_p2
         assign prev2 = ptr_r[k-2];
      end else begin : g_z2
         assign prev2 = 1'b0;
      end
      // decoder sets only the start stage and clears the rest
      assign ptr_nxt[k] = load_i ? (start_stg_i == STG_W'(k)) :
                          shift_i ? (two_i ? prev2 : prev1) :
                          ptr_r[k];
   end

   // pointer register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ptr_r <= '0;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   // binary shadow follows the same load and shift
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stage_r <= '0;
      end else if (load_i) begin
         stage_r <= start_stg_i;
      end else if (shift_i) begin
         stage_r <= stage_r + (two_i ? STG_W'(STEP_TWO) : STG_W'(STEP_ONE));
      end
   end

   assign active_o = |ptr_r;
   assign stage_o  = stage_r;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_load_onehot;
      @(posedge clk_i) disable iff (!rst_n_i)
      load_i |=> ($onehot(ptr_r) && ptr_r[stage_r]
                  && stage_r == $past(start_stg_i));
   endproperty
   a_load_onehot: assert property (p_load_onehot)
      else $error("pointer not one-hot at start stage after load");

endmodule : cra_col_ptr
`default_nettype wire

// *** core/cra_merge.sv ***
// column readout addressing: merges the two column buses into one stream
// assumes the sequencer presents bus a in phase 0 and bus b in phase 1
`timescale 1ns/100ps
`default_nettype none
module cra_merge
   import cra_pkg::*;
(
   input  wire logic   clk_i,   // system clock
   input  wire logic   rst_n_i, // sync reset, active low
   cra_stream_if.merge s        // sequencer side
);
   // ------------------------------------------------------------------
   // one pixel per system clock: bus a slot, then bus b slot
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s.pix_data  <= '0;
         s.pix_col   <= '0;
         s.pix_valid <= 1'b0;
      end else if (s.run) begin
         s.pix_data  <= s.phase ? s.bus_b : s.bus_a;
         s.pix_col   <= s.phase ? s.col_b : s.col_a;
         s.pix_valid <= 1'b1;
      end else begin
         s.pix_valid <= 1'b0;                         // no pixel outside a row
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_alternate;
      @(posedge clk_i) disable iff (!rst_n_i)
      (s.run && !s.phase) ##1 (s.run && s.phase) |=>
         (s.pix_col == $past(s.col_b) && $past(s.pix_col) == $past(s.col_a, 2));
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("merged stream does not alternate bus a then bus b");

endmodule : cra_merge
`default_nettype wire

// *** core/cra_top.sv ***
// column readout addressing: sequencer, APB registers and pixel stream
// assumes APB master on clk_i, column buses valid in the cycle the
// column pair is presented, and blank_end_i pulsed once per row
`timescale 1ns/100ps
`default_nettype none
module cra_top
   import cra_pkg::*;
(
   input  wire logic             clk_i,        // system clock, 40 MHz
   input  wire logic             rst_n_i,      // sync reset, active low
   input  wire logic             psel_i,       // APB select
   input  wire logic             penable_i,    // APB access phase
   input  wire logic             pwrite_i,     // APB write
   input  wire logic [11:0]      paddr_i,      // APB byte address
   input  wire logic [31:0]      pwdata_i,     // APB write data
   output logic      [31:0]      prdata_o,     // APB read data
   output logic                  pready_o,     // APB ready
   output logic                  pslverr_o,    // APB error
   input  wire logic             blank_end_i,  // end of row blanking
   input  wire logic [PIX_W-1:0] bus_a_i,      // even-column bus
   input  wire logic [PIX_W-1:0] bus_b_i,      // odd-column bus
   output logic                  sync_load_o,  // start-load control
   output logic                  col_en_o,     // column switches enabled
   output logic      [COL_W-1:0] col_a_o,      // column on bus a
   output logic      [COL_W-1:0] col_b_o,      // column on bus b
   output logic      [PIX_W-1:0] pix_data_o,   // pixel stream data
   output logic      [COL_W-1:0] pix_col_o,    // pixel stream column
   output logic                  pix_valid_o   // pixel stream valid
);
   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic             sub_r;        // sub-sampling enable
   logic             inner_r;      // column_inner_swap_bit
   logic             outer_r;      // column_outer_swap_bit
   logic [COL_W-1:0] start_col_r;  // window start column
   logic [COL_W-1:0] stop_col_r;   // window last column
   logic             cfg_sub_r;    // mode latched for the running row
   logic [3:0]       cfg_off_r;    // pattern offsets for the running row
   cra_state_t       state_r;      // sequencer state
   cra_state_t       state_nxt;    // next sequencer state
   logic             phase_r;      // half-rate divider phase
   logic             shift_en;     // pointer shift pulse
   logic             row_end;      // next shift leaves the window
   logic             ptr_active;   // pointer still inside the array
   logic [STG_W-1:0] stage;        // current pointer stage
   logic [STG_W:0]   stage_sum;    // stage after the next shift
   logic [COL_W-1:0] base_col;     // first column of the stage
   logic [3:0]       off_sel;      // offsets from the control bits
   logic             apb_acc;      // APB access phase
   logic             apb_wr;       // APB write strobe
   logic             addr_hit;     // address is mapped

   cra_stream_if s ();             // link to the merger

   // ------------------------------------------------------------------
   // APB slave: zero wait states, error on unmapped addresses
   // ------------------------------------------------------------------
   assign apb_acc   = psel_i && penable_i;
   assign apb_wr    = apb_acc && pwrite_i;
   assign addr_hit  = (paddr_i == REG_CTRL) || (paddr_i == REG_START) ||
                      (paddr_i == REG_STOP) || (paddr_i == REG_STAT);
   assign pready_o  = 1'b1;
   assign pslverr_o = apb_acc && !addr_hit;

   // control register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sub_r   <= 1'b0;
         inner_r <= 1'b0;
         outer_r <= 1'b0;
      end else if (apb_wr && paddr_i == REG_CTRL) begin
         sub_r   <= pwdata_i[CTRL_SUB_BIT];
         inner_r <= pwdata_i[CTRL_INNER_BIT];
         outer_r <= pwdata_i[CTRL_OUTER_BIT];
      end
   end

   // window registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         start_col_r <= START_RST;
         stop_col_r  <= STOP_RST;
      end else if (apb_wr) begin
         if (paddr_i == REG_START) begin
            start_col_r <= pwdata_i[COL_W-1:0];
         end
         if (paddr_i == REG_STOP) begin
            stop_col_r <= pwdata_i[COL_W-1:0];
         end
      end
   end

   // read mux, unused bits read as zero
   always_comb begin
      prdata_o = '0;
      case (paddr_i)
         REG_CTRL: begin
            prdata_o[CTRL_SUB_BIT]   = sub_r;
            prdata_o[CTRL_INNER_BIT] = inner_r;
            prdata_o[CTRL_OUTER_BIT] = outer_r;
         end
         REG_START: prdata_o[COL_W-1:0] = start_col_r;
         REG_STOP:  prdata_o[COL_W-1:0] = stop_col_r;
         REG_STAT: begin
            prdata_o[STAT_BUSY_BIT] = (state_r != ST_IDLE);
            prdata_o[STAT_STG_LSB +: STG_W] = stage;
         end
         default:   prdata_o = '0;
      endcase
   end

   // ------------------------------------------------------------------
   // sequencer: idle, one load cycle, then half-rate shifting
   // ------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (blank_end_i) begin
               state_nxt = ST_LOAD;
            end
         end
         ST_LOAD: begin
            state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (blank_end_i) begin
               state_nxt = ST_LOAD;  // new row restarts the pointer
            end else if (shift_en && row_end) begin
               state_nxt = ST_IDLE;  // window finished
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // divider: shift on every second clock of a row
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         phase_r <= 1'b0;
      end else if (state_r == ST_RUN) begin
         phase_r <= ~phase_r;
      end else begin
         phase_r <= 1'b0;
      end
   end
   assign shift_en = (state_r == ST_RUN) && phase_r;

   // pattern offsets picked from the control bits
   always_comb begin
      case ({sub_r, inner_r, outer_r})
         3'b110:  off_sel = OFF_INNER;
         3'b101:  off_sel = OFF_OUTER;
         3'b111:  off_sel = OFF_BOTH;
         default: off_sel = OFF_PLAIN;
      endcase
   end

   // mode is frozen at load so a row never changes pattern midway
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg_sub_r <= 1'b0;
         cfg_off_r <= OFF_PLAIN;
      end else if (state_r == ST_LOAD) begin
         cfg_sub_r <= sub_r;
         cfg_off_r <= off_sel;
      end
   end

   // ------------------------------------------------------------------
   // column pointer
   // ------------------------------------------------------------------
   cra_col_ptr u_ptr (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .load_i      (state_r == ST_LOAD),
      .start_stg_i (start_col_r[COL_W-1:1]),
      .shift_i     (shift_en),
      .two_i       (cfg_sub_r),
      .active_o    (ptr_active),
      .stage_o     (stage)
   );

   // window end: next shift passes the stop stage, or the pointer has already left the array
   assign stage_sum = {1'b0, stage} + (cfg_sub_r ? STEP_TWO : STEP_ONE);
   assign row_end   = (stage_sum > {1'b0, stop_col_r[COL_W-1:1]}) ||
                      !ptr_active;

   // columns presented for the selected stage
   assign base_col = {stage, 1'b0};
   assign col_a_o  = base_col + COL_W'(cfg_off_r[3:2]);
   assign col_b_o  = base_col + COL_W'(cfg_off_r[1:0]);

   // switches open during load, closed while the row runs
   assign sync_load_o = (state_r == ST_LOAD);
   assign col_en_o    = (state_r == ST_RUN);

   // ------------------------------------------------------------------
   // stream merger
   // ------------------------------------------------------------------
   assign s.run   = (state_r == ST_RUN);
   assign s.phase = phase_r;
   assign s.bus_a = bus_a_i;
   assign s.bus_b = bus_b_i;
   assign s.col_a = col_a_o;
   assign s.col_b = col_b_o;

   cra_merge u_merge (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .s       (s)
   );

   assign pix_data_o  = s.pix_data;
   assign pix_col_o   = s.pix_col;
   assign pix_valid_o = s.pix_valid;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_half_rate;
      (shift_en && !blank_end_i) |=> !shift_en ##1 (shift_en || state_r != ST_RUN);
   endproperty
   a_half_rate: assert property (p_half_rate)
      else $error("pointer shift is not at half the clock rate");

   property p_bus_parity;
      (col_en_o && !cfg_sub_r) |-> (!col_a_o[0] && col_b_o == col_a_o + 11'h001);
   endproperty
   a_bus_parity: assert property (p_bus_parity)
      else $error("bus a not even or bus b not the next odd column");

   property p_pixel_rate;
      (state_r == ST_RUN) [*2] |-> pix_valid_o ##1 pix_valid_o;
   endproperty
   a_pixel_rate: assert property (p_pixel_rate)
      else $error("pixel missing while row runs");

   property p_load_open;
      (state_r == ST_IDLE && blank_end_i) |=> (sync_load_o && !col_en_o)
                                            ##1 (!sync_load_o && col_en_o);
   endproperty
   a_load_open: assert property (p_load_open)
      else $error("load not one cycle with switches open");

   property p_start_pos;
      $fell(sync_load_o) |-> (stage == start_col_r[COL_W-1:1] && !phase_r);
   endproperty
   a_start_pos: assert property (p_start_pos)
      else $error("shifting does not begin at the start stage");

   property p_step_one;
      (shift_en && !cfg_sub_r && !blank_end_i) |=> stage == $past(stage) + 10'h001;
   endproperty
   a_step_one: assert property (p_step_one)
      else $error("normal mode did not advance one stage");

   property p_step_two;
      (shift_en && cfg_sub_r && !blank_end_i) |=> stage == $past(stage) + 10'h002;
   endproperty
   a_step_two: assert property (p_step_two)
      else $error("sub-sampling did not advance two stages");

   property p_inner;
      (col_en_o && cfg_sub_r && cfg_off_r == OFF_INNER) |->
         (col_b_o == col_a_o + 11'h002 && col_a_o == base_col);
   endproperty
   a_inner: assert property (p_inner)
      else $error("inner swap pattern wrong");

   property p_outer;
      (col_en_o && cfg_sub_r && cfg_off_r == OFF_OUTER) |->
         (col_a_o == base_col + 11'h001 && col_b_o == base_col + 11'h003);
   endproperty
   a_outer: assert property (p_outer)
      else $error("outer swap pattern wrong");

   property p_both;
      (col_en_o && cfg_sub_r && cfg_off_r == OFF_BOTH) |->
         (col_a_o == base_col + 11'h002 && col_b_o == base_col + 11'h003);
   endproperty
   a_both: assert property (p_both)
      else $error("double swap pattern wrong");

   c_normal_row: cover property (sync_load_o && !sub_r ##1 col_en_o [*4]);
   c_sub_row:    cover property (sync_load_o && sub_r ##1 col_en_o [*4]);
   c_both_swap:  cover property (col_en_o && cfg_off_r == OFF_BOTH ##1 pix_valid_o);
   c_row_end:    cover property (shift_en && row_end ##1 state_r == ST_IDLE);

endmodule : cra_top
`default_nettype wire

// *** tb/cra_bus_model.sv ***
// column bus model: pixel samples on the even and odd column buses
// assumes the column outputs of the block select what each bus carries
`timescale 1ns/100ps
`default_nettype none
module cra_bus_model
   import cra_pkg::*;
(
   input  wire logic             col_en_i, // column switches closed
   input  wire logic [COL_W-1:0] col_a_i,  // column on the even bus
   input  wire logic [COL_W-1:0] col_b_i,  // column on the odd bus
   output logic      [PIX_W-1:0] bus_a_o,  // even bus sample
   output logic      [PIX_W-1:0] bus_b_o   // odd bus sample
);
   // --------------------------------------------------------------
   // bus drive
   // --------------------------------------------------------------
   // sample is the scrambled column; open switches give the inverse
   assign bus_a_o = col_en_i ? col_a_i[9:0] ^ 10'h2A5 : ~(col_a_i[9:0] ^ 10'h2A5);
   assign bus_b_o = col_en_i ? col_b_i[9:0] ^ 10'h2A5 : ~(col_b_i[9:0] ^ 10'h2A5);
endmodule : cra_bus_model
`default_nettype wire

// *** tb/tb.sv ***
// column readout bench: register reads and row streams in every mode
// assumes cra_top runs on one 40 MHz clock; the column bus model is combinational and has no clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end
module tb
   import cra_pkg::*;
;
   logic             clk_i, rst_n_i, psel_i, penable_i, pwrite_i, blank_end_i;
   logic [11:0]      paddr_i;     // byte address
   logic [31:0]      pwdata_i;    // write data
   logic [31:0]      prdata_o;    // read data
   logic             pready_o, pslverr_o, sync_load_o, col_en_o, pix_valid_o;
   logic [PIX_W-1:0] bus_a_i, bus_b_i, pix_data_o;
   logic [COL_W-1:0] col_a_o, col_b_o, pix_col_o;
   int               mismatches = 0;
   int               n_tests = 0;
   int               cyc = 0;     // timeout counter

   cra_top cra_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .blank_end_i(blank_end_i), .bus_a_i(bus_a_i), .bus_b_i(bus_b_i),
      .sync_load_o(sync_load_o), .col_en_o(col_en_o), .col_a_o(col_a_o),
      .col_b_o(col_b_o), .pix_data_o(pix_data_o), .pix_col_o(pix_col_o),
      .pix_valid_o(pix_valid_o));
   cra_bus_model cra_bus_model_i (.col_en_i(col_en_o), .col_a_i(col_a_o),
      .col_b_i(col_b_o), .bus_a_o(bus_a_i), .bus_b_o(bus_b_i));

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   // one apb transfer, held until ready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      err = pslverr_o;
      `CHK(pready_o, 1'b1)
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   // reset values and an unmapped address
   task automatic regs();
      logic [31:0] d;
      logic        e;
      apb(1'b0, REG_CTRL, 32'h0, d, e);
      `CHK(d, 32'h0)
      `CHK(e, 1'b0)
      apb(1'b0, REG_START, 32'h0, d, e);
      `CHK(d, 32'h0)
      apb(1'b0, REG_STOP, 32'h0, d, e);
      `CHK(d, 32'h000004FF)
      apb(1'b0, 12'h010, 32'h0, d, e);
      `CHK(e, 1'b1)
      $display("register test done");
   endtask : regs

   // one row: expected columns built from mode, start and stop
   task automatic row(input logic [2:0] ctl, input logic [10:0] st, input logic [10:0] sp);
      logic [10:0] q[$];
      logic [31:0] d;
      logic        e;
      int          s, oa, ob, k;
      apb(1'b1, REG_CTRL, {29'h0, ctl}, d, e);
      apb(1'b1, REG_START, {21'h0, st}, d, e);
      apb(1'b1, REG_STOP, {21'h0, sp}, d, e);
      oa = ctl[0] ? (ctl[2] ? (ctl[1] ? 2 : 1) : 0) : 0;
      ob = ctl[0] ? (ctl[2] ? 3 : (ctl[1] ? 2 : 1)) : 1;
      for (s = int'(st[10:1]); s <= int'(sp[10:1]) && s < NUM_STG; s += ctl[0] ? 2 : 1) begin
         q.push_back(11'(2 * s + oa));
         q.push_back(11'(2 * s + ob));
      end
      @(posedge clk_i) blank_end_i <= 1'b1;
      @(posedge clk_i) blank_end_i <= 1'b0;
      @(negedge clk_i);
      `CHK(sync_load_o, 1'b1)
      `CHK(col_en_o, 1'b0)
      k = 0;
      repeat (2000) begin
         @(negedge clk_i);
         if (pix_valid_o === 1'b1) begin
            `CHK(pix_col_o, q[k])
            `CHK(pix_data_o, q[k][9:0] ^ 10'h2A5)
            k++;
         end else if (k > 0) break;
      end
      `CHK(k, q.size())
      apb(1'b0, REG_STAT, 32'h0, d, e);
      `CHK(d, 32'(s) << STAT_STG_LSB)
      `CHK(e, 1'b0)
      $display("row mode %0h start %0d done", ctl, st);
   endtask : row

   // blanking end in mid-row: busy seen, pointer reloaded, full row again
   task automatic restart();
      logic [31:0] d;
      logic        e;
      int          k;
      apb(1'b1, REG_CTRL, 32'h0, d, e);
      apb(1'b1, REG_START, 32'h8, d, e);
      apb(1'b1, REG_STOP, 32'h17, d, e);
      @(posedge clk_i) blank_end_i <= 1'b1;
      @(posedge clk_i) blank_end_i <= 1'b0;
      apb(1'b0, REG_STAT, 32'h0, d, e);
      `CHK(d[STAT_BUSY_BIT], 1'b1)
      @(posedge clk_i) blank_end_i <= 1'b1;
      @(posedge clk_i) blank_end_i <= 1'b0;
      @(negedge clk_i);
      `CHK(sync_load_o, 1'b1)
      k = 0;
      repeat (100) begin
         @(negedge clk_i);
         if (pix_valid_o === 1'b1) begin
            if (k == 0) `CHK(pix_col_o, 11'h008)
            k++;
         end else if (k > 0) break;
      end
      `CHK(k, 16)
      $display("restart test done");
   endtask : restart

   // counts and verdict
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   // ------------------------------------------------------------------
   // clock, timeout and main sequence
   // ------------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      {rst_n_i, psel_i, penable_i, pwrite_i, blank_end_i} = 5'h00;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      regs();
      row(3'h0, 11'd8, 11'd23);
      row(3'h1, 11'd8, 11'd23);
      row(3'h3, 11'd8, 11'd23);
      row(3'h5, 11'd8, 11'd23);
      row(3'h7, 11'd8, 11'd23);
      row(3'h6, 11'd8, 11'd23);
      row(3'h0, 11'd1272, 11'h4FF);
      row(3'h1, 11'd638, 11'h4FF);
      restart();
      conclude();
   end
endmodule : tb
`default_nettype wire
